// ### logic/asp_ctrl.sv
// host controller for an asynchronous static memory with common data pins
`timescale 1ns/100ps
module asp_ctrl
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic wide_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [1:0] be_i,
    input wire logic [asp_pkg::ASP_ADDR_W-1:0] addr_i,
    input wire logic [asp_pkg::ASP_DATA_W-1:0] wdata_i,
    output logic ready_o,
    output logic rvalid_o,
    output logic [asp_pkg::ASP_DATA_W-1:0] rdata_o,
    output logic [asp_pkg::ASP_ADDR_W-1:0] word_addr_o,
    output logic chip_sel_n_o,
    output logic write_n_o,
    output logic out_gate_n_o,
    output logic low_lane_sel_n_o,
    output logic high_lane_sel_n_o,
    input wire logic [asp_pkg::ASP_DATA_W-1:0] shared_data_pins_i,
    output logic [asp_pkg::ASP_DATA_W-1:0] shared_data_pins_o,
    output logic shared_data_pins_oe_o
);
    import asp_pkg::*;
    asp_state_e state;
    logic [3:0] cnt;
    logic [1:0] be;
    logic wide;
    logic is_write;
    logic capture;
    logic [1:0] lane_n;
    logic [ASP_DATA_W-1:0] cap_data;
    logic cap_done;

    // lane encoding and read capture
    asp_lane_mux u_lanes
    (
        .ref_clk_i(ref_clk_i),
        .wide_i(wide),
        .be_i(be),
        .capture_i(capture),
        .pins_i(shared_data_pins_i),
        .lane_n_o(lane_n),
        .rdata_o(cap_data)
    );
    assign capture = (state == ASP_READ) && (cnt == 4'h1);

    // sequencer: setup, strobe window, hold, recovery
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            state <= ASP_IDLE;
            cnt <= 4'h0;
            be <= 2'h0;
            wide <= 1'b0;
            is_write <= 1'b0;
        end
        else
        begin
            case (state)
                ASP_IDLE:
                begin
                    if (req_i)
                    begin
                        be <= be_i;
                        wide <= wide_i;
                        is_write <= we_i;
                        state <= ASP_SETUP;
                    end
                end
                ASP_SETUP:
                begin
                    cnt <= is_write ? ASP_WIN_CNT : ASP_ACC_CNT;
                    state <= is_write ? ASP_WRITE : ASP_READ;
                end
                ASP_WRITE:
                begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h1)
                        state <= ASP_HOLD;
                end
                ASP_HOLD:
                begin
                    cnt <= ASP_REC_CNT;
                    state <= ASP_RECOVER;
                end
                ASP_READ:
                begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h1)
                    begin
                        cnt <= ASP_REC_CNT;
                        state <= ASP_RECOVER;
                    end
                end
                ASP_RECOVER:
                begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h1)
                        state <= ASP_IDLE;
                end
                default: state <= ASP_IDLE;
            endcase
        end
    end

    // address and write data latched at acceptance, held past end of write
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            word_addr_o <= ASP_ADDR_RST;
            shared_data_pins_o <= ASP_DATA_RST;
        end
        else if (state == ASP_IDLE && req_i)
        begin
            word_addr_o <= addr_i;
            shared_data_pins_o <= wdata_i;
        end
    end

    // memory control strobes, all registered
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            chip_sel_n_o <= 1'b1;
            write_n_o <= 1'b1;
            out_gate_n_o <= 1'b1;
            low_lane_sel_n_o <= 1'b1;
            high_lane_sel_n_o <= 1'b1;
            shared_data_pins_oe_o <= 1'b0;
        end
        else
        begin
            // select and lanes asserted from setup, on the same edge as the strobe
            chip_sel_n_o <= !(state == ASP_SETUP || state == ASP_WRITE ||
                state == ASP_READ);
            low_lane_sel_n_o <= (state == ASP_SETUP || state == ASP_WRITE ||
                state == ASP_READ) ? lane_n[0] : 1'b1;
            high_lane_sel_n_o <= (state == ASP_SETUP || state == ASP_WRITE ||
                state == ASP_READ) ? lane_n[1] : 1'b1;
            write_n_o <= !(state == ASP_SETUP && is_write) &&
                !(state == ASP_WRITE && cnt != 4'h1);
            out_gate_n_o <= !((state == ASP_SETUP && !is_write) ||
                (state == ASP_READ && cnt != 4'h1));
            // drive data only on writes; released before any read gate
            shared_data_pins_oe_o <= (state == ASP_SETUP && is_write) ||
                state == ASP_WRITE;
        end
    end

    // handshake back to the user; the lane capture lands one edge before rdata
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            ready_o <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o <= ASP_DATA_RST;
            cap_done <= 1'b0;
        end
        else
        begin
            ready_o <= (state == ASP_IDLE) && !req_i;
            cap_done <= capture; // captured word is settled from here
            rvalid_o <= cap_done;
            if (cap_done)
                rdata_o <= cap_data;
        end
    end

    // bus ownership never overlaps a read gate
    a_no_contention: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !(shared_data_pins_oe_o && !out_gate_n_o))
        else $error("data driven while read gate low");
    // write strobe stays high whenever the read gate is low
    a_read_strobe: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !out_gate_n_o |-> write_n_o)
        else $error("write strobe low during read");
    sequence s_win;
        !write_n_o [*1] ##1 write_n_o;
    endsequence
    // write window length exactly one cycle, the rounded minimum
    a_win_len: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        $fell(write_n_o) |-> s_win)
        else $error("write window length wrong");
    // select low while strobe low
    a_sel_cover: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !write_n_o |-> !chip_sel_n_o)
        else $error("strobe low without select");
    // address steady through and one edge past the window
    a_addr_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !write_n_o |=> $stable(word_addr_o))
        else $error("address moved during write");
    // data driven across the whole window
    a_data_drv: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !write_n_o |-> shared_data_pins_oe_o && $stable(shared_data_pins_o))
        else $error("write data not held");
    // select rises only after the strobe has risen
    a_sel_after: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        $rose(chip_sel_n_o) |-> $past(write_n_o))
        else $error("select ended before strobe");
    // recovery spacing before next select
    a_spacing: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        $rose(chip_sel_n_o) |-> chip_sel_n_o [*2])
        else $error("access spacing too short");
endmodule

// ### logic/asp_pkg.sv
// constants and types for the static memory host controller
package asp_pkg;
    localparam int ASP_ADDR_W = 20;
    localparam int ASP_DATA_W = 16;
    localparam int ASP_CLK_NS = 100;
    // write window minimums, gate high and gate low, both grades
    localparam int ASP_WIN_FAST_NS = 7;
    localparam int ASP_WIN_SLOW_NS = 12;
    localparam int ASP_WIN_GLOW_FAST_NS = 10;
    localparam int ASP_WIN_GLOW_SLOW_NS = 15;
    // setup of address, lanes, select and data to end of write
    localparam int ASP_SETUP_SLOW_NS = 12;
    localparam int ASP_DATA_SLOW_NS = 8;
    // read access and cycle time, slow grade
    localparam int ASP_ACCESS_SLOW_NS = 15;
    localparam int ASP_CYCLE_SLOW_NS = 15;
    // least times round up to whole cycles, never below one
    function automatic int asp_cyc(input int ns);
        int c;
        c = (ns + ASP_CLK_NS - 1) / ASP_CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int ASP_WIN_CYC = asp_cyc(ASP_WIN_GLOW_SLOW_NS);
    localparam int ASP_ACC_CYC = asp_cyc(ASP_ACCESS_SLOW_NS);
    localparam int ASP_REC_CYC = asp_cyc(ASP_CYCLE_SLOW_NS);
    localparam logic [3:0] ASP_WIN_CNT = 4'(ASP_WIN_CYC);
    localparam logic [3:0] ASP_ACC_CNT = 4'(ASP_ACC_CYC);
    localparam logic [3:0] ASP_REC_CNT = 4'(ASP_REC_CYC);
    localparam logic [ASP_ADDR_W-1:0] ASP_ADDR_RST = 20'h00000;
    localparam logic [ASP_DATA_W-1:0] ASP_DATA_RST = 16'h0000;
    typedef enum logic [2:0] {ASP_IDLE, ASP_SETUP, ASP_WRITE, ASP_HOLD, ASP_READ,
        ASP_RECOVER} asp_state_e;
endpackage

// ### logic/asp_lane_mux.sv
// lane selects and read data capture, per organisation
`timescale 1ns/100ps
module asp_lane_mux
(
    input wire logic ref_clk_i,
    input wire logic wide_i,
    input wire logic [1:0] be_i,
    input wire logic capture_i,
    input wire logic [asp_pkg::ASP_DATA_W-1:0] pins_i,
    output logic [1:0] lane_n_o,
    output logic [asp_pkg::ASP_DATA_W-1:0] rdata_o
);
    import asp_pkg::*;
    // narrow parts have no lane selects; both stay low
    always_comb
    begin
        lane_n_o = wide_i ? ~be_i : 2'h0;
    end
    // capture only enabled lanes, the others read zero
    always_ff @(posedge ref_clk_i)
    begin
        if (capture_i)
        begin
            rdata_o[7:0] <= be_i[0] ? pins_i[7:0] : 8'h00;
            rdata_o[15:8] <= (wide_i && be_i[1]) ? pins_i[15:8] : 8'h00;
        end
    end
endmodule

// ### verification/asp_sram_model.sv
// behavioural static memory that answers the host controller's pins
`timescale 1ns/100ps
module asp_sram_model
(
    input wire logic [asp_pkg::ASP_ADDR_W-1:0] word_addr_i,
    input wire logic chip_sel_n_i,
    input wire logic write_n_i,
    input wire logic out_gate_n_i,
    input wire logic low_lane_sel_n_i,
    input wire logic high_lane_sel_n_i,
    input wire logic [asp_pkg::ASP_DATA_W-1:0] host_data_i,
    input wire logic host_oe_i,
    output logic [asp_pkg::ASP_DATA_W-1:0] pins_o,
    output logic clash_o
);
    import asp_pkg::*;
    logic [15:0] mem [0:255];
    logic [15:0] dout;
    logic [7:0] a;
    logic [1:0] lane_n, drv, drv_q;
    logic wr_act, rd_mode, late_sel, clash;
    // shallow array on the low address bits, cleared at start
    initial
    begin
        foreach (mem[i]) mem[i] = 16'h0000;
        late_sel = 1'b0;
        clash_o = 1'b0;
    end
    assign a = word_addr_i[7:0];
    assign lane_n = {high_lane_sel_n_i, low_lane_sel_n_i};
    assign wr_act = !chip_sel_n_i && !write_n_i;
    // store the selected lanes while the write window is open
    always @*
    begin
        if (wr_act && !lane_n[0]) mem[a][7:0] = host_data_i[7:0];
        if (wr_act && !lane_n[1]) mem[a][15:8] = host_data_i[15:8];
    end
    // select falling inside a strobe keeps the outputs off
    always @(chip_sel_n_i)
        late_sel = !chip_sel_n_i && !write_n_i;
    // lanes drive only in read mode with their select low
    assign rd_mode = !chip_sel_n_i && write_n_i && !out_gate_n_i && !late_sel;
    assign drv = rd_mode ? ~lane_n : 2'b00;
    // drivers switch 3 ns late; data settles 5 ns after address
    assign #3 drv_q = drv;
    assign #5 dout = mem[a];
    // released lanes show the inverse, never a stale copy
    assign pins_o[7:0] = host_oe_i ? host_data_i[7:0] : (drv_q[0] ? dout[7:0] : ~dout[7:0]);
    assign pins_o[15:8] = host_oe_i ? host_data_i[15:8] : (drv_q[1] ? dout[15:8] : ~dout[15:8]);
    // sticky flag when both sides drive at once
    assign clash = host_oe_i && (drv_q != 2'b00);
    always @(posedge clash)
        clash_o = 1'b1;
endmodule

// ### verification/asp_ctrl_tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/100ps
module asp_ctrl_tb;
    import asp_pkg::*;
    logic clk, srst, wide, req, we, ready, rvalid, cs_n, wr_n, gate_n, lo_n, hi_n, oe, clash;
    logic [1:0] be;
    logic [ASP_ADDR_W-1:0] addr, waddr;
    logic [ASP_DATA_W-1:0] wdata, rdata, pins_o, pins_i;
    int error_cnt, n_tests;
    asp_ctrl asp_ctrl_i (.ref_clk_i(clk), .srst_i(srst), .wide_i(wide), .req_i(req), .we_i(we),
        .be_i(be), .addr_i(addr), .wdata_i(wdata), .ready_o(ready), .rvalid_o(rvalid),
        .rdata_o(rdata), .word_addr_o(waddr), .chip_sel_n_o(cs_n), .write_n_o(wr_n),
        .out_gate_n_o(gate_n), .low_lane_sel_n_o(lo_n), .high_lane_sel_n_o(hi_n),
        .shared_data_pins_i(pins_i), .shared_data_pins_o(pins_o), .shared_data_pins_oe_o(oe));
    asp_sram_model asp_sram_model_i (.word_addr_i(waddr), .chip_sel_n_i(cs_n),
        .write_n_i(wr_n), .out_gate_n_i(gate_n), .low_lane_sel_n_i(lo_n),
        .high_lane_sel_n_i(hi_n), .host_data_i(pins_o), .host_oe_i(oe), .pins_o(pins_i),
        .clash_o(clash));
    // 100 ns clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // cut a hang short
    initial
    begin
        #200000;
        error_cnt++;
        complete_run();
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held one cycle, released after the taking edge
    task automatic issue(input logic w, input logic [19:0] a, input logic [15:0] d,
        input logic [1:0] b);
        req = 1'b1;
        we = w;
        addr = a;
        wdata = d;
        be = b;
        @(posedge clk);
        #1;
        req = 1'b0;
    endtask
    task automatic do_write(input logic [19:0] a, input logic [15:0] d, input logic [1:0] b);
        logic [1:0] ln;
        ln = wide ? ~b : 2'b00;
        issue(1'b1, a, d, b);
        @(posedge clk);
        #1;
        chk("write strobes", {cs_n, wr_n, oe, hi_n, lo_n}, {3'b001, ln});
        chk("write addr data", {waddr, pins_o}, {a, d});
        @(posedge clk);
        #1;
        chk("write close", {cs_n, wr_n, oe, hi_n, lo_n}, {3'b011, ln});
        chk("write data held", {waddr, pins_o}, {a, d});
        @(posedge clk);
        #1;
        chk("write end", {cs_n, wr_n, oe, hi_n, lo_n, waddr}, {5'b11011, a});
        repeat (2) @(posedge clk);
        #1;
        chk("write ready", ready, 40'h1);
    endtask
    task automatic do_read(input logic [19:0] a, input logic [1:0] b, input logic [15:0] exp);
        issue(1'b0, a, 16'h0000, b);
        @(posedge clk);
        #1;
        chk("read strobes", {ready, cs_n, wr_n, gate_n, oe, waddr}, {5'b00100, a});
        repeat (2) @(posedge clk);
        #1;
        chk("read data", {rvalid, rdata}, {1'b1, exp});
    endtask
    // idle pins after reset
    task automatic t_reset();
        @(posedge clk);
        #1;
        chk("idle pins", {cs_n, wr_n, gate_n, hi_n, lo_n, oe}, 6'h3e);
        chk("ready idle", ready, 40'h1);
    endtask
    // whole words, back to back
    task automatic t_words();
        do_write(20'h00005, 16'h1234, 2'b11);
        do_write(20'h00006, 16'h5678, 2'b11);
        do_read(20'h00005, 2'b11, 16'h1234);
        do_read(20'h00006, 2'b11, 16'h5678);
    endtask
    // lanes merge on write, disabled lanes read zero
    task automatic t_lanes();
        do_write(20'h00005, 16'habcd, 2'b01);
        do_write(20'h00005, 16'h9876, 2'b10);
        do_read(20'h00005, 2'b11, 16'h98cd);
        do_read(20'h00005, 2'b10, 16'h9800);
        do_read(20'h00005, 2'b01, 16'h00cd);
    endtask
    // byte organisation with lane selects held low
    task automatic t_narrow();
        wide = 1'b0;
        do_write(20'h00009, 16'h4321, 2'b01);
        do_read(20'h00009, 2'b01, 16'h0021);
        wide = 1'b1;
    endtask
    initial
    begin
        srst = 1'b1;
        wide = 1'b1;
        req = 1'b0;
        we = 1'b0;
        be = 2'b00;
        addr = 20'h00000;
        wdata = 16'h0000;
        error_cnt = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_words();
        t_lanes();
        t_narrow();
        chk("bus clash", clash, 40'h0);
        complete_run();
    end
endmodule
